// *** hdl/mac_pkg.sv ***
// Constants and types of the multiply-accumulate datapath
package mac_pkg;
    // ***********************************************************
    // Widths
    // ***********************************************************
    localparam int ACC_W = 40;
    localparam int OPD_W = 16;
    localparam int MUL_W = 17;
    localparam int SCL_W = 33;
    localparam int PRD_W = 34;
    localparam int GRD_LO = 32;
    localparam int ADR_W = 8;

    // ***********************************************************
    // Register offsets (byte addresses)
    // ***********************************************************
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_TRAP = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_ACCA_LO = 8'h0C;
    localparam logic [7:0] A_ACCA_HI = 8'h10;
    localparam logic [7:0] A_ACCB_LO = 8'h14;
    localparam logic [7:0] A_ACCB_HI = 8'h18;

    // ***********************************************************
    // Field positions and reset values
    // ***********************************************************
    localparam int CTL_CLIP_A = 7;
    localparam int CTL_CLIP_B = 6;
    localparam int CTL_SATW = 4;
    localparam int CTL_FRAC = 0;
    localparam logic [7:0] CTL_MASK = 8'hD1;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam int TEN_A = 0;
    localparam int TEN_B = 1;
    localparam logic [7:0] TEN_MASK = 8'h03;
    localparam logic [7:0] TEN_RST = 8'h00;
    localparam int ST_CLIP_A = 2;
    localparam int ST_CLIP_B = 3;

    // ***********************************************************
    // Clip limits
    // ***********************************************************
    localparam logic [39:0] SAT31_POS = 40'h007FFFFFFF;
    localparam logic [39:0] SAT31_NEG = 40'hFF80000000;
    localparam logic [39:0] SAT39_POS = 40'h7FFFFFFFFF;
    localparam logic [39:0] SAT39_NEG = 40'h8000000000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ***********************************************************
    // Types
    // ***********************************************************
    typedef enum logic [2:0] {
        OP_NOP, OP_MPY, OP_MAC, OP_MSC, OP_ADD, OP_SUB, OP_LOAD, OP_PRODUCT
    } mac_op_e;

    typedef struct packed {
        logic valid;
        mac_op_e op;
        logic src_b;
        logic dst_b;
        logic sgn_x;
        logic sgn_y;
        logic byte_mode;
        logic [15:0] opd_x;
        logic [15:0] opd_y;
        logic [39:0] data;
        logic shift_en;
        logic shift_left;
        logic [3:0] shift_amt;
    } mac_req_s;

    typedef struct packed {
        logic valid;
        logic [31:0] product;
    } mac_rsp_s;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } mac_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mac_axi_rsp_s;

    typedef struct packed {
        logic [39:0] acc_a;
        logic [39:0] acc_b;
        logic ovf_a;
        logic ovf_b;
        logic clip_a;
        logic clip_b;
        logic cat_a;
        logic cat_b;
        logic [7:0] ctrl;
        logic [7:0] trap_en;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        mac_rsp_s rsp;
    } mac_state_s;

    localparam mac_state_s ST_RST = '0;
endpackage

// *** hdl/mac_datapath.sv ***
// Multiply-accumulate datapath with AXI4-Lite control and status
`timescale 1ns/1ps
`default_nettype none
module mac_datapath (
    input wire logic CLK,
    input wire logic RESETN,
    input wire mac_pkg::mac_axi_req_s AXI_REQ,
    output mac_pkg::mac_axi_rsp_s AXI_RSP,
    input wire mac_pkg::mac_req_s OP_REQ,
    output mac_pkg::mac_rsp_s OP_RSP,
    output logic [39:0] ACC_A,
    output logic [39:0] ACC_B,
    output logic [5:0] STATUS_FLAGS,
    output logic TRAP_REQ
);
    import mac_pkg::*;

    mac_state_s st_r;
    mac_state_s st_nxt;

    // ***********************************************************
    // Multiplier and scaler
    // ***********************************************************
    function automatic logic [16:0] ext17(input logic [15:0] v, input logic sgn,
                                          input logic byt);
        logic msb;
        msb = byt ? v[7] : v[15];
        if (byt) begin
            ext17 = {{9{sgn & msb}}, v[7:0]};
        end else begin
            ext17 = {sgn & msb, v};
        end
    endfunction

    logic [16:0] mx;
    logic [16:0] my;
    logic signed [33:0] prod;
    logic is_dsp;
    logic frac;
    logic [32:0] scaled;
    logic [39:0] prod40;

    assign mx = ext17(OP_REQ.opd_x, OP_REQ.sgn_x, OP_REQ.byte_mode);
    assign my = ext17(OP_REQ.opd_y, OP_REQ.sgn_y, OP_REQ.byte_mode);
    // Both inputs already carry their sign in bit 16, so one signed multiply
    // covers every sign mix
    assign prod = $signed(mx) * $signed(my);
    assign is_dsp = OP_REQ.op inside {OP_MPY, OP_MAC, OP_MSC};
    assign frac = st_r.ctrl[CTL_FRAC];
    // Fractional result drops the duplicate sign bit
    assign scaled = frac ? {prod[31:0], 1'b0} : prod[32:0];
    assign prod40 = {{(ACC_W - SCL_W){scaled[32]}}, scaled};

    // ***********************************************************
    // Shifter, adder and clip stage
    // ***********************************************************
    logic [39:0] shifted;
    logic [39:0] addend;
    logic [39:0] acc_src;
    logic [39:0] in_x;
    logic [39:0] in_y;
    logic [40:0] sum41;
    logic [39:0] sum;
    logic sub;
    logic zero_x;
    logic cat;
    logic grd;
    logic ovf31;
    logic clip_en;
    logic wide;
    logic true_neg;
    logic do_clip;
    logic [39:0] clip_val;
    logic [39:0] result;
    logic acc_op;

    always_comb begin
        if (!OP_REQ.shift_en) begin
            shifted = OP_REQ.data;
        end else if (OP_REQ.shift_left) begin
            shifted = OP_REQ.data << OP_REQ.shift_amt;
        end else begin
            shifted = $signed(OP_REQ.data) >>> OP_REQ.shift_amt;
        end
    end

    assign addend = is_dsp ? prod40 : shifted;
    assign sub = OP_REQ.op inside {OP_MSC, OP_SUB};
    assign zero_x = OP_REQ.op inside {OP_MPY, OP_LOAD};
    assign acc_src = OP_REQ.src_b ? st_r.acc_b : st_r.acc_a;
    assign in_x = zero_x ? '0 : acc_src;
    assign in_y = sub ? ~addend : addend;
    // Borrow is active low, so a subtract feeds a carry of one
    assign sum41 = {in_x[39], in_x} + {in_y[39], in_y} + {40'h0, sub};
    assign sum = sum41[39:0];
    assign cat = (in_x[39] == in_y[39]) && (sum[39] != in_x[39]);
    assign grd = !((&sum[39:GRD_LO]) || !(|sum[39:GRD_LO]));
    assign ovf31 = !((&sum[39:31]) || !(|sum[39:31]));
    assign clip_en = OP_REQ.dst_b ? st_r.ctrl[CTL_CLIP_B] : st_r.ctrl[CTL_CLIP_A];
    assign wide = st_r.ctrl[CTL_SATW];
    // After a bit-39 overflow the sum's sign is wrong; the operands' is not
    assign true_neg = cat ? in_x[39] : sum[39];
    assign do_clip = clip_en && (wide ? cat : (cat || ovf31));

    always_comb begin
        if (wide) begin
            clip_val = true_neg ? SAT39_NEG : SAT39_POS;
        end else begin
            clip_val = true_neg ? SAT31_NEG : SAT31_POS;
        end
    end

    assign result = do_clip ? clip_val : sum;
    assign acc_op = OP_REQ.valid && !(OP_REQ.op inside {OP_NOP, OP_PRODUCT});

    // ***********************************************************
    // Register read view
    // ***********************************************************
    function automatic logic [31:0] rd_view(input mac_state_s s, input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'b00};
        rd_view = '0;
        unique case (w)
            A_CTRL: rd_view = {24'h0, s.ctrl};
            A_TRAP: rd_view = {24'h0, s.trap_en};
            A_STAT: rd_view = {24'h0, s.cat_b, s.cat_a, s.clip_a | s.clip_b,
                               s.ovf_a | s.ovf_b, s.clip_b, s.clip_a, s.ovf_b, s.ovf_a};
            A_ACCA_LO: rd_view = s.acc_a[31:0];
            A_ACCA_HI: rd_view = {24'h0, s.acc_a[39:32]};
            A_ACCB_LO: rd_view = s.acc_b[31:0];
            A_ACCB_HI: rd_view = {24'h0, s.acc_b[39:32]};
            default: rd_view = '0;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = ({a[7:2], 2'b00} <= A_ACCB_HI);
    endfunction

    // ***********************************************************
    // Next state
    // ***********************************************************
    logic aw_ok;
    logic w_ok;
    logic ar_ok;
    logic [7:0] wa;

    assign aw_ok = AXI_REQ.awvalid && !st_r.aw_got && !st_r.bvalid;
    assign w_ok = AXI_REQ.wvalid && !st_r.w_got && !st_r.bvalid;
    assign ar_ok = AXI_REQ.arvalid && !st_r.rvalid;
    assign wa = {st_r.awaddr[7:2], 2'b00};

    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp.valid = 1'b0;
        if (aw_ok) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = AXI_REQ.awaddr;
        end
        if (w_ok) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = AXI_REQ.wdata;
            st_nxt.wstrb = AXI_REQ.wstrb;
        end
        if (st_r.bvalid && AXI_REQ.bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = mapped(st_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (st_r.wstrb[0]) begin
                if (wa == A_CTRL) begin
                    st_nxt.ctrl = st_r.wdata[7:0] & CTL_MASK;
                end
                if (wa == A_TRAP) begin
                    st_nxt.trap_en = st_r.wdata[7:0] & TEN_MASK;
                end
                // Clip flags clear by writing one; a clip in the same cycle
                // is applied below and wins
                if (wa == A_STAT) begin
                    st_nxt.clip_a = st_r.clip_a & !st_r.wdata[ST_CLIP_A];
                    st_nxt.clip_b = st_r.clip_b & !st_r.wdata[ST_CLIP_B];
                end
            end
        end
        if (st_r.rvalid && AXI_REQ.rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (ar_ok) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_view(st_r, AXI_REQ.araddr);
            st_nxt.rresp = mapped(AXI_REQ.araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (acc_op) begin
            if (OP_REQ.dst_b) begin
                st_nxt.acc_b = result;
                st_nxt.ovf_b = grd;
                st_nxt.cat_b = cat;
                st_nxt.clip_b = st_nxt.clip_b | do_clip;
            end else begin
                st_nxt.acc_a = result;
                st_nxt.ovf_a = grd;
                st_nxt.cat_a = cat;
                st_nxt.clip_a = st_nxt.clip_a | do_clip;
            end
        end
        if (OP_REQ.valid && OP_REQ.op == OP_PRODUCT) begin
            st_nxt.rsp.valid = 1'b1;
            if (OP_REQ.byte_mode) begin
                st_nxt.rsp.product = {16'h0, prod[15:0]};
            end else begin
                st_nxt.rsp.product = prod[31:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ***********************************************************
    // Outputs
    // ***********************************************************
    always_comb begin
        AXI_RSP.awready = !st_r.aw_got && !st_r.bvalid;
        AXI_RSP.wready = !st_r.w_got && !st_r.bvalid;
        AXI_RSP.bvalid = st_r.bvalid;
        AXI_RSP.bresp = st_r.bresp;
        AXI_RSP.arready = !st_r.rvalid;
        AXI_RSP.rvalid = st_r.rvalid;
        AXI_RSP.rdata = st_r.rdata;
        AXI_RSP.rresp = st_r.rresp;
    end

    assign OP_RSP = st_r.rsp;
    assign ACC_A = st_r.acc_a;
    assign ACC_B = st_r.acc_b;
    assign STATUS_FLAGS = {st_r.clip_a | st_r.clip_b, st_r.ovf_a | st_r.ovf_b,
                           st_r.clip_b, st_r.clip_a, st_r.ovf_b, st_r.ovf_a};
    assign TRAP_REQ = (st_r.ovf_a && st_r.trap_en[TEN_A]) ||
                      (st_r.ovf_b && st_r.trap_en[TEN_B]);

    // ***********************************************************
    // Assertions
    // ***********************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    function automatic logic [31:0] ref_mul(input logic [15:0] x, input logic [15:0] y,
                                            input logic sx, input logic sy);
        logic [63:0] a;
        logic [63:0] b;
        logic [63:0] p;
        a = sx ? {{48{x[15]}}, x} : {48'h0, x};
        b = sy ? {{48{y[15]}}, y} : {48'h0, y};
        p = a * b;
        ref_mul = p[31:0];
    endfunction

    logic plain_a;
    assign plain_a = acc_op && !OP_REQ.dst_b && !st_r.ctrl[CTL_CLIP_A];

    sequence s_wr_taken;
        AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready;
    endsequence

    sequence s_a_clip_hit;
        acc_op && !OP_REQ.dst_b && st_r.ctrl[CTL_CLIP_A] && !wide && ovf31;
    endsequence

    a_zero_fill: assert property (
        !OP_REQ.sgn_x && !OP_REQ.byte_mode |-> mx[16] == 1'b0)
        else $error("unsigned operand not zero filled");
    a_sign_fill: assert property (
        OP_REQ.sgn_x && !OP_REQ.byte_mode |-> mx[16] == OP_REQ.opd_x[15])
        else $error("signed operand not sign filled");
    a_word_product: assert property (
        OP_REQ.valid && OP_REQ.op == OP_PRODUCT && !OP_REQ.byte_mode
        |=> OP_RSP.valid && OP_RSP.product == ref_mul($past(OP_REQ.opd_x),
            $past(OP_REQ.opd_y), $past(OP_REQ.sgn_x), $past(OP_REQ.sgn_y)))
        else $error("word product wrong");
    a_byte_product: assert property (
        OP_REQ.valid && OP_REQ.op == OP_PRODUCT && OP_REQ.byte_mode
        |=> OP_RSP.valid && OP_RSP.product[31:16] == 16'h0)
        else $error("byte product wider than 16 bits");
    a_mpy_extend: assert property (
        plain_a && OP_REQ.op == OP_MPY |=> (&ACC_A[39:32]) || !(|ACC_A[39:32]))
        else $error("product not sign extended");
    a_frac_scale: assert property (
        plain_a && OP_REQ.op == OP_MPY && frac |=> ACC_A[0] == 1'b0)
        else $error("fractional product not scaled");
    a_load_pass: assert property (
        plain_a && OP_REQ.op == OP_LOAD && !OP_REQ.shift_en
        |=> ACC_A == $past(OP_REQ.data))
        else $error("load did not pass data");
    a_sub_path: assert property (
        plain_a && OP_REQ.op == OP_SUB && !OP_REQ.src_b && !OP_REQ.shift_en
        |=> ACC_A == $past(ACC_A) - $past(OP_REQ.data))
        else $error("subtract result wrong");
    a_guard_flag: assert property (
        plain_a |=> STATUS_FLAGS[0] == !((&ACC_A[39:32]) || !(|ACC_A[39:32])))
        else $error("guard overflow flag wrong");
    a_clip_limit: assert property (
        s_a_clip_hit |=> STATUS_FLAGS[2] && ((&ACC_A[39:31]) || !(|ACC_A[39:31])))
        else $error("bit 31 clip missing");
    a_any_flags: assert property (
        STATUS_FLAGS[4] == (STATUS_FLAGS[0] || STATUS_FLAGS[1]) &&
        STATUS_FLAGS[5] == (STATUS_FLAGS[2] || STATUS_FLAGS[3]))
        else $error("combined flags wrong");
    a_trap_gate: assert property (
        TRAP_REQ |-> (STATUS_FLAGS[0] || STATUS_FLAGS[1]) && |st_r.trap_en[1:0])
        else $error("trap without enabled overflow");
    a_write_answer: assert property (
        s_wr_taken |-> ##2 AXI_RSP.bvalid)
        else $error("write response late");
    a_reset_clear: assert property (
        @(posedge CLK) disable iff (1'b0)
        !RESETN |=> ACC_A == '0 && ACC_B == '0 && STATUS_FLAGS == '0 && !TRAP_REQ)
        else $error("reset left state behind");
endmodule
`default_nettype wire

// *** sim/mac_pipe_model.sv ***
// Pipeline stand-in that hands operations to the datapath
`timescale 1ns/1ps
`default_nettype none
module mac_pipe_model (
    input wire logic clk,
    output var mac_pkg::mac_req_s op_req
);
    import mac_pkg::*;

    initial begin
        op_req = '0;
    end

    // One cycle of valid per call; stale operands are scrambled so nothing leans on them
    task automatic issue(input mac_req_s q);
        @(posedge clk);
        op_req <= q;
        @(posedge clk);
        op_req.valid <= 1'b0;
        op_req.opd_x <= ~q.opd_x;
        op_req.opd_y <= ~q.opd_y;
        op_req.data <= ~q.data;
    endtask
endmodule
`default_nettype wire

// *** sim/mac_datapath_tb_top.sv ***
// Self-checking bench of the multiply-accumulate datapath
`timescale 1ns/1ps
`default_nettype none
module mac_datapath_tb_top;
    import mac_pkg::*;
    logic CLK;
    logic RESETN;
    mac_axi_req_s AXI_REQ;
    mac_axi_rsp_s AXI_RSP;
    mac_req_s OP_REQ;
    mac_rsp_s OP_RSP;
    logic [39:0] ACC_A;
    logic [39:0] ACC_B;
    logic [5:0] STATUS_FLAGS;
    logic TRAP_REQ;
    logic [31:0] rd;
    logic [1:0] rs;
    int miscompares = 0;
    int comparisons = 0;

    mac_datapath uut (.CLK(CLK), .RESETN(RESETN), .AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP),
        .OP_REQ(OP_REQ), .OP_RSP(OP_RSP), .ACC_A(ACC_A), .ACC_B(ACC_B),
        .STATUS_FLAGS(STATUS_FLAGS), .TRAP_REQ(TRAP_REQ));
    mac_pipe_model pipe (.clk(CLK), .op_req(OP_REQ));

    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    // ****************
    // Helpers
    // ****************
    task automatic end_sim();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hang();
        miscompares++;
        $display("[ERR] %0t bus handshake timed out", $time);
        end_sim();
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge CLK);
        AXI_REQ.awvalid <= 1'b1;
        AXI_REQ.awaddr <= a;
        AXI_REQ.wvalid <= 1'b1;
        AXI_REQ.wdata <= d;
        AXI_REQ.bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge CLK);
            if (AXI_REQ.awvalid && AXI_RSP.awready) AXI_REQ.awvalid <= 1'b0;
            if (AXI_REQ.wvalid && AXI_RSP.wready) AXI_REQ.wvalid <= 1'b0;
            if (AXI_RSP.bvalid) begin
                r = AXI_RSP.bresp;
                AXI_REQ.bready <= 1'b0;
                #1;
                return;
            end
        end
        hang();
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge CLK);
        AXI_REQ.arvalid <= 1'b1;
        AXI_REQ.araddr <= a;
        AXI_REQ.rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge CLK);
            if (AXI_REQ.arvalid && AXI_RSP.arready) AXI_REQ.arvalid <= 1'b0;
            if (AXI_RSP.rvalid) begin
                d = AXI_RSP.rdata;
                r = AXI_RSP.rresp;
                AXI_REQ.rready <= 1'b0;
                return;
            end
        end
        hang();
    endtask

    // Operands: ab = {src_b, dst_b}, sg = {byte_mode, sgn_x, sgn_y}
    task automatic mul(mac_op_e o, logic [1:0] ab, logic [2:0] sg, logic [15:0] x,
        logic [15:0] y);
        mac_req_s q;
        q = '0;
        q.valid = 1'b1;
        q.op = o;
        {q.src_b, q.dst_b} = ab;
        {q.byte_mode, q.sgn_x, q.sgn_y} = sg;
        q.opd_x = x;
        q.opd_y = y;
        pipe.issue(q);
        #1;
    endtask

    // Shifter control: sh = {shift_en, shift_left, shift_amt}
    task automatic acc(mac_op_e o, logic [1:0] ab, logic [39:0] d, logic [5:0] sh);
        mac_req_s q;
        q = '0;
        q.valid = 1'b1;
        q.op = o;
        {q.src_b, q.dst_b} = ab;
        q.data = d;
        {q.shift_en, q.shift_left, q.shift_amt} = sh;
        pipe.issue(q);
        #1;
    endtask

    task automatic rst();
        RESETN <= 1'b0;
        repeat (3) @(posedge CLK);
        RESETN <= 1'b1;
        @(posedge CLK);
        #1;
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        chk(ACC_A, 40'h0);
        chk(ACC_B, 40'h0);
        chk(STATUS_FLAGS, 40'h0);
        chk(TRAP_REQ, 40'h0);
        axi_rd(A_CTRL, rd, rs);
        chk(rd, 40'h0);
    endtask

    task automatic t_mult();
        mul(OP_MPY, 2'h0, 3'h3, 16'h8000, 16'h7FFF);
        chk(ACC_A, 40'hFFC0008000);
        mul(OP_MPY, 2'h1, 3'h0, 16'hFFFF, 16'h0002);
        chk(ACC_B, 40'h000001FFFE);
        mul(OP_PRODUCT, 2'h0, 3'h2, 16'hFFFF, 16'h8000);
        chk(OP_RSP.valid, 40'h1);
        chk(OP_RSP.product, 40'hFFFF8000);
        mul(OP_PRODUCT, 2'h0, 3'h4, 16'hAB10, 16'hCD10);
        chk(OP_RSP.product, 40'h00000100);
        @(posedge CLK);
        #1;
        chk(OP_RSP.valid, 40'h0);
        chk(ACC_A, 40'hFFC0008000);
    endtask

    task automatic t_frac();
        axi_wr(A_CTRL, 32'h00000001, rs);
        mul(OP_MPY, 2'h0, 3'h3, 16'h4000, 16'h4000);
        chk(ACC_A, 40'h0020000000);
        mul(OP_MPY, 2'h0, 3'h3, 16'h8000, 16'h4000);
        chk(ACC_A, 40'hFFC0000000);
        axi_wr(A_CTRL, 32'h00000000, rs);
    endtask

    task automatic t_accum();
        acc(OP_LOAD, 2'h0, 40'h100, 6'h00);
        chk(ACC_A, 40'h100);
        mul(OP_MAC, 2'h0, 3'h3, 16'h0002, 16'h0003);
        chk(ACC_A, 40'h106);
        mul(OP_MSC, 2'h0, 3'h3, 16'h0002, 16'h0003);
        chk(ACC_A, 40'h100);
        mul(OP_MAC, 2'h2, 3'h3, 16'h0002, 16'h0003);
        chk(ACC_A, 40'h20004);
        acc(OP_SUB, 2'h0, 40'h4, 6'h00);
        chk(ACC_A, 40'h20000);
        acc(OP_ADD, 2'h0, 40'h1, 6'h34);
        chk(ACC_A, 40'h20010);
        acc(OP_LOAD, 2'h1, 40'hFFFFFFFF00, 6'h24);
        chk(ACC_B, 40'hFFFFFFFFF0);
        chk(STATUS_FLAGS, 40'h0);
    endtask

    task automatic t_overflow();
        acc(OP_LOAD, 2'h0, 40'h7FFFFFFFFF, 6'h00);
        acc(OP_ADD, 2'h0, 40'h1, 6'h00);
        chk(ACC_A, 40'h8000000000);
        chk(STATUS_FLAGS, 40'h11);
        chk(TRAP_REQ, 40'h0);
        axi_rd(A_STAT, rd, rs);
        chk(rd, 40'h51);
        axi_wr(A_TRAP, 32'h00000001, rs);
        chk(TRAP_REQ, 40'h1);
        acc(OP_LOAD, 2'h1, 40'h0100000000, 6'h00);
        chk(STATUS_FLAGS, 40'h13);
        acc(OP_LOAD, 2'h0, 40'h10, 6'h00);
        chk(STATUS_FLAGS, 40'h12);
        chk(TRAP_REQ, 40'h0);
        acc(OP_LOAD, 2'h1, 40'h0, 6'h00);
        axi_wr(A_TRAP, 32'h00000000, rs);
    endtask

    task automatic t_clip();
        axi_wr(A_CTRL, 32'h00000080, rs);
        acc(OP_LOAD, 2'h0, 40'h7FFFFFFF, 6'h00);
        acc(OP_ADD, 2'h0, 40'h1, 6'h00);
        chk(ACC_A, 40'h007FFFFFFF);
        chk(STATUS_FLAGS, 40'h24);
        axi_wr(A_STAT, 32'h00000004, rs);
        chk(STATUS_FLAGS, 40'h0);
        axi_wr(A_CTRL, 32'h00000090, rs);
        acc(OP_LOAD, 2'h0, 40'h7FFFFFFFFF, 6'h00);
        acc(OP_ADD, 2'h0, 40'h1, 6'h00);
        chk(ACC_A, 40'h7FFFFFFFFF);
        chk(STATUS_FLAGS, 40'h35);
        acc(OP_LOAD, 2'h1, 40'h7FFFFFFF, 6'h00);
        acc(OP_ADD, 2'h3, 40'h1, 6'h00);
        chk(ACC_B, 40'h0080000000);
        // Negative bit-31 clip on accumulator B
        axi_wr(A_CTRL, 32'h00000040, rs);
        acc(OP_SUB, 2'h3, 40'h0180000000, 6'h00);
        chk(ACC_B, 40'hFF80000000);
        chk(STATUS_FLAGS, 40'h3D);
    endtask

    task automatic t_regs();
        axi_wr(A_CTRL, 32'h000000FF, rs);
        axi_rd(A_CTRL, rd, rs);
        chk(rd, 40'hD1);
        axi_rd(A_ACCA_HI, rd, rs);
        chk(rd, 40'h7F);
        axi_rd(8'h20, rd, rs);
        chk({rs, rd}, {6'h00, 2'h2, 32'h0});
        axi_wr(8'h20, 32'h00000001, rs);
        chk(rs, 40'h2);
    endtask

    initial begin
        RESETN = 1'b0;
        AXI_REQ = '0;
        AXI_REQ.wstrb = 4'hF;
        rst();
        t_reset();
        t_mult();
        t_frac();
        t_accum();
        t_overflow();
        t_clip();
        t_regs();
        // Mid-run reset must wipe clipped state again
        rst();
        t_reset();
        end_sim();
    end
endmodule
`default_nettype wire
